// file: slt_regs.svh
`ifndef SLT_REGS_SVH
`define SLT_REGS_SVH

// Register byte offsets on the APB port.
`define SLT_CTRL_OFS 8'h00
`define SLT_CFG_OFS 8'h04
`define SLT_STATUS_OFS 8'h08
`define SLT_ERR_OFS 8'h0c
`define SLT_ISTAT_OFS 8'h10
`define SLT_IMASK_OFS 8'h14
`define SLT_SIG_OFS 8'h18
`define SLT_EXPSIG_OFS 8'h1c

// Field positions.
`define SLT_CTRL_HALL_START 0
`define SLT_CTRL_LOGIC_START 1
`define SLT_CFG_LBE 0
`define SLT_CFG_CSE 1
`define SLT_CFG_DST 2
`define SLT_EV_HALL_DONE 0
`define SLT_EV_LOGIC_DONE 1
`define SLT_EV_FAIL 2

// Reset values of the nonvolatile copies and the expected signature.
`define SLT_CFG_RESET 3'h3
`define SLT_EXPSIG_RESET 31'h2a5f13c7

// Structure of the logic under test.
`define SLT_CHAINS 31
`define SLT_CHAIN_LEN 8
`define SLT_HALL_STEPS 8

// Timing: both tests last this long at the clock rate below.
`define SLT_TEST_MS 30
`define SLT_CLK_MHZ 200
`define SLT_TEST_CYC (`SLT_TEST_MS * 1000 * `SLT_CLK_MHZ)
`define SLT_HALL_STEP_CYC (`SLT_TEST_CYC / `SLT_HALL_STEPS)

// Angle code of one emulated step and the accepted error, in LSBs of 12 bits.
`define SLT_ANGLE_STEP 12'h200
`define SLT_ANGLE_TOL 12'h020

`endif

// file: slt_pkg.sv
`include "slt_regs.svh"

package slt_pkg;

    // APB request as seen by the slave.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } slt_apb_req_t;

    // APB answer driven by the slave.
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } slt_apb_rsp_t;

    // Front-end switch configuration during the transducer test.
    typedef struct packed {
        logic testCfg;
        logic currentDir;
        logic [2:0] elementSel;
    } slt_fe_t;

    // Whole state of the self-test block.
    typedef struct packed {
        slt_apb_rsp_t apb;
        logic irq;
        logic pupDone;
        logic [2:0] cfg;
        logic lRun;
        logic lDone;
        logic [31:0] lCnt;
        logic [30:0] lfsr;
        logic [30:0] signature_register;
        logic [`SLT_CHAINS-1:0][`SLT_CHAIN_LEN-1:0] chains;
        logic [30:0] expSig;
        logic hRun;
        logic sdn;
        logic hBad;
        logic [31:0] hCnt;
        slt_fe_t fe;
        logic errFail;
        logic [2:0] iStat;
        logic [2:0] iMask;
    } slt_state_t;

endpackage

// file: slt_self_test.sv
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "slt_regs.svh"

// Contract
// - Logic under test forms 31 concurrent chains.
// - 31-bit LFSR feeds one bit per chain.
// - Signature register compresses chain outputs, 31 bits.
// - Logic and transducer tests run concurrently.
// - Logic self-test lasts about 30 ms.
// - Power-up logic test only when enabled.
// - Power-up transducer test when its enable set.
// - Special command starts the transducer test.
// - Block bit set ignores special start command.
// - Completion: done flag set, running flag clear.
// - Sticky fail flag; host clears before test.
// - Transducer self-test lasts about 30 ms.
// - Test configuration steps current and elements.
module slt_self_test #(
    parameter int unsigned LOGIC_TEST_CYC = `SLT_TEST_CYC,
    parameter int unsigned HALL_STEP_CYC = `SLT_HALL_STEP_CYC
) (
    // Clock and synchronous reset.
    input wire logic clk,
    input wire logic resetn,
    // APB slave port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // Interrupt request, high while an unmasked event bit is set.
    output logic irq,
    // Front-end switch control and measured angle.
    output slt_pkg::slt_fe_t feCtrl,
    input wire logic [11:0] angleIn
);

    // ************************************************************
    // State, request bundle and scan chain wiring
    // ************************************************************

    // Registered state and its next value.
    slt_pkg::slt_state_t r;
    slt_pkg::slt_state_t next_r;
    // Bus request gathered into one bundle.
    slt_pkg::slt_apb_req_t req;
    // Chain outputs and the chains after one shift.
    logic [`SLT_CHAINS-1:0] chainOut;
    logic [`SLT_CHAINS-1:0][`SLT_CHAIN_LEN-1:0] chainShift;
    // Angle error of the current step, modulo one turn.
    logic [11:0] angleErr;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign angleErr = angleIn - (12'(r.fe.elementSel) * `SLT_ANGLE_STEP);

    // Each chain takes its own LFSR bit in and hands its last bit to the signature.
    for (genvar g = 0; g < `SLT_CHAINS; g++) begin : gChain
        assign chainOut[g] = r.chains[g][`SLT_CHAIN_LEN-1];
        assign chainShift[g] = {r.chains[g][`SLT_CHAIN_LEN-2:0], r.lfsr[g]};
    end

    // Outputs come straight from the state flip-flops.
    assign pready = r.apb.pready;
    assign pslverr = r.apb.pslverr;
    assign prdata = r.apb.prdata;
    assign irq = r.irq;
    assign feCtrl = r.fe;

    // ************************************************************
    // Next-state logic
    // ************************************************************

    // All bus, test and interrupt behaviour is computed here in one pass.
    always_comb begin
        logic setup;
        logic access;
        logic wr;
        logic hallStart;
        logic logicStart;
        logic hallEnd;
        logic logicEnd;
        logic stepEnd;
        logic angleOk;
        logic [2:0] events;
        setup = 1'b0;
        access = 1'b0;
        wr = 1'b0;
        hallStart = 1'b0;
        logicStart = 1'b0;
        hallEnd = 1'b0;
        logicEnd = 1'b0;
        stepEnd = 1'b0;
        angleOk = 1'b0;
        events = 3'h0;
        next_r = r;

        // A setup cycle is answered in the following access cycle.
        setup = req.psel && !req.penable;
        access = req.psel && req.penable && r.apb.pready;
        wr = access && req.pwrite;
        next_r.apb.pready = setup;

        // Read data and the error answer are prepared during setup.
        if (setup) begin
            next_r.apb.pslverr = 1'b0;
            next_r.apb.prdata = 32'h0;
            unique case (req.paddr)
                `SLT_CTRL_OFS: begin
                    next_r.apb.prdata = 32'h0;
                end
                `SLT_CFG_OFS: begin
                    next_r.apb.prdata = {29'h0, r.cfg};
                end
                `SLT_STATUS_OFS: begin
                    next_r.apb.prdata = {28'h0, r.lDone, r.lRun, r.sdn, r.hRun};
                end
                `SLT_ERR_OFS: begin
                    next_r.apb.prdata = {31'h0, r.errFail};
                end
                `SLT_ISTAT_OFS: begin
                    next_r.apb.prdata = {29'h0, r.iStat};
                end
                `SLT_IMASK_OFS: begin
                    next_r.apb.prdata = {29'h0, r.iMask};
                end
                `SLT_SIG_OFS: begin
                    next_r.apb.prdata = {1'h0, r.signature_register};
                end
                `SLT_EXPSIG_OFS: begin
                    next_r.apb.prdata = {1'h0, r.expSig};
                end
                default: begin
                    // Unmapped addresses read zero and report an error.
                    next_r.apb.pslverr = 1'b1;
                end
            endcase
        end

        // Plain register writes take effect at the completing edge.
        if (wr && req.paddr == `SLT_CFG_OFS) begin
            next_r.cfg = req.pwdata[2:0];
        end
        if (wr && req.paddr == `SLT_IMASK_OFS) begin
            next_r.iMask = req.pwdata[2:0];
        end
        if (wr && req.paddr == `SLT_EXPSIG_OFS) begin
            next_r.expSig = req.pwdata[30:0];
        end

        // The first cycle after reset launches the power-up tests.
        if (!r.pupDone) begin
            next_r.pupDone = 1'b1;
            logicStart = r.cfg[`SLT_CFG_LBE];
            hallStart = r.cfg[`SLT_CFG_CSE];
        end

        // The special command starts the transducer test unless blocked.
        if (wr && req.paddr == `SLT_CTRL_OFS) begin
            if (req.pwdata[`SLT_CTRL_HALL_START] && !r.cfg[`SLT_CFG_DST]) begin
                hallStart = 1'b1;
            end
            if (req.pwdata[`SLT_CTRL_LOGIC_START]) begin
                logicStart = 1'b1;
            end
        end

        // Logic test: shift chains, advance LFSR, fold outputs into signature.
        if (r.lRun) begin
            next_r.chains = chainShift;
            next_r.lfsr = {r.lfsr[29:0], r.lfsr[30] ^ r.lfsr[27]};
            next_r.signature_register = {r.signature_register[29:0], r.signature_register[30] ^ r.signature_register[27]} ^ chainOut;
            next_r.lCnt = r.lCnt + 32'h1;
            if (r.lCnt == LOGIC_TEST_CYC - 1) begin
                logicEnd = 1'b1;
                next_r.lRun = 1'b0;
                next_r.lDone = 1'b1;
                if (next_r.signature_register != r.expSig) begin
                    events[`SLT_EV_FAIL] = 1'b1;
                end
            end
        end else if (logicStart) begin
            // The chains and signature restart from a known seed; a busy test ignores starts.
            next_r.lRun = 1'b1;
            next_r.lDone = 1'b0;
            next_r.lCnt = 32'h0;
            next_r.lfsr = 31'h1;
            next_r.signature_register = 31'h0;
            next_r.chains = '0;
        end

        // Transducer test: step current and elements, judge each step's angle.
        if (r.hRun) begin
            next_r.hCnt = r.hCnt + 32'h1;
            stepEnd = (r.hCnt == HALL_STEP_CYC - 1);
            angleOk = (angleErr <= `SLT_ANGLE_TOL) || (angleErr >= 12'h0 - `SLT_ANGLE_TOL);
            if (stepEnd) begin
                next_r.hCnt = 32'h0;
                next_r.hBad = r.hBad || !angleOk;
                if (r.fe.elementSel == 3'(`SLT_HALL_STEPS - 1)) begin
                    hallEnd = 1'b1;
                    next_r.hRun = 1'b0;
                    next_r.sdn = 1'b1;
                    next_r.fe = '0;
                    if (r.hBad || !angleOk) begin
                        events[`SLT_EV_FAIL] = 1'b1;
                    end
                end else begin
                    next_r.fe.elementSel = r.fe.elementSel + 3'h1;
                    next_r.fe.currentDir = next_r.fe.elementSel[2];
                end
            end
        end else if (hallStart) begin
            // Front end swaps into the test configuration at step zero.
            next_r.hRun = 1'b1;
            next_r.sdn = 1'b0;
            next_r.hBad = 1'b0;
            next_r.hCnt = 32'h0;
            next_r.fe = '{testCfg: 1'b1, currentDir: 1'b0, elementSel: 3'h0};
        end

        // Done events follow the last cycle of each test.
        events[`SLT_EV_LOGIC_DONE] = logicEnd;
        events[`SLT_EV_HALL_DONE] = hallEnd;

        // Fail flag is sticky, cleared by writing one; a new failure wins.
        if (wr && req.paddr == `SLT_ERR_OFS && req.pwdata[0]) begin
            next_r.errFail = 1'b0;
        end
        if (events[`SLT_EV_FAIL]) begin
            next_r.errFail = 1'b1;
        end

        // Event bits are write-one-to-clear, with a same-cycle event winning.
        if (wr && req.paddr == `SLT_ISTAT_OFS) begin
            next_r.iStat = r.iStat & ~req.pwdata[2:0];
        end
        next_r.iStat = next_r.iStat | events;
        next_r.irq = |(next_r.iStat & next_r.iMask);
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Synchronous active-low reset loads constants only.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
            r.cfg <= `SLT_CFG_RESET;
            r.expSig <= `SLT_EXPSIG_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    // Helper terms read by the checks only: a completing write of each command.
    logic wr_hall_cmd;
    logic wr_err_clr;
    assign wr_hall_cmd = psel && penable && r.apb.pready && pwrite
        && paddr == `SLT_CTRL_OFS && pwdata[0];
    assign wr_err_clr = psel && penable && r.apb.pready && pwrite
        && paddr == `SLT_ERR_OFS && pwdata[0];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // A chain's first stage takes the LFSR bit of the previous cycle.
    chk_chain_feed: assert property (r.lRun |=> r.chains[5][0] == $past(r.lfsr[5]))
        else $error("chain did not take its LFSR bit");

    // The running LFSR never locks up at zero.
    chk_lfsr_alive: assert property (r.lRun |-> r.lfsr != 31'h0)
        else $error("LFSR stuck at zero");

    // The signature folds in the chain outputs each running cycle.
    chk_signature_register_fold: assert property (r.lRun |=> r.signature_register == ({$past(r.signature_register[29:0]),
        $past(r.signature_register[30] ^ r.signature_register[27])} ^ $past(chainOut)))
        else $error("signature did not fold chain outputs");

    // A transducer start during a running logic test is still taken.
    // The last logic cycle is left out, since the logic test ends there anyway.
    chk_concurrent: assert property (r.lRun && !r.hRun && wr_hall_cmd && !r.cfg[2]
        && r.lCnt != LOGIC_TEST_CYC - 1 |=> r.hRun && r.lRun)
        else $error("tests block each other");

    // The logic test ends exactly at its cycle count.
    chk_logic_length: assert property (r.lRun && r.lCnt == LOGIC_TEST_CYC - 1
        |=> !r.lRun && r.lDone)
        else $error("logic test length wrong");

    // A wrong final signature raises the fail flag.
    chk_sig_compare: assert property (r.lRun && r.lCnt == LOGIC_TEST_CYC - 1
        && next_r.signature_register != r.expSig |=> r.errFail)
        else $error("signature mismatch not flagged");

    // Power-up starts follow the enable copies.
    chk_pup_logic: assert property ($rose(r.pupDone) |-> r.lRun == $past(r.cfg[0]))
        else $error("power-up logic test wrong");

    // Power-up transducer start follows its enable.
    chk_pup_hall: assert property ($rose(r.pupDone) |-> r.hRun == $past(r.cfg[1]))
        else $error("power-up transducer test wrong");

    // An unblocked special command starts an idle transducer test.
    chk_special_go: assert property (!r.hRun && wr_hall_cmd && !r.cfg[2] |=> r.hRun)
        else $error("special command not taken");

    // A blocked special command is ignored.
    chk_special_block: assert property (!r.hRun && r.pupDone && wr_hall_cmd && r.cfg[2]
        |=> !r.hRun)
        else $error("blocked special command started test");

    // Falling running flag coincides with the done flag.
    chk_done_flag: assert property ($fell(r.hRun) |-> r.sdn && r.fe.testCfg == 1'b0)
        else $error("completion flags inconsistent");

    // The fail flag holds until software writes one to it.
    chk_fail_sticky: assert property (r.errFail && !(wr_err_clr) |=> r.errFail)
        else $error("fail flag lost");

    // Steps advance the element and current direction together.
    chk_step_walk: assert property (r.hRun && r.hCnt == HALL_STEP_CYC - 1
        && r.fe.elementSel != 3'h7 |=> r.fe.elementSel == $past(r.fe.elementSel) + 3'h1
        && r.fe.currentDir == r.fe.elementSel[2])
        else $error("front-end step wrong");

    // A transducer test enters at step zero in the test configuration, done flag clear.
    chk_hall_enter: assert property ($rose(r.hRun) |-> r.fe.testCfg && !r.sdn
        && r.fe.elementSel == 3'h0)
        else $error("transducer test entered wrongly");

    // The step counter never passes the end of a step.
    chk_hall_bound: assert property (r.hRun |-> r.hCnt < HALL_STEP_CYC)
        else $error("step counter overran");

    // A step that missed its angle fails the whole transducer test.
    chk_hall_fail: assert property (r.hRun && r.hCnt == HALL_STEP_CYC - 1
        && r.fe.elementSel == 3'h7 && r.hBad |=> r.errFail && !r.hRun)
        else $error("failed transducer step not flagged");

    // The end of the logic test leaves its event bit set.
    chk_logic_event: assert property (r.lRun && r.lCnt == LOGIC_TEST_CYC - 1
        |=> r.iStat[1])
        else $error("logic done event missing");

endmodule

// file: slt_fe_model.sv
`timescale 1ns/1ps

// ****************************************
// Front-end model that answers the transducer test.
// ****************************************
module slt_fe_model (
    // Clock of the sensor core.
    input wire logic clk,
    // Switch configuration from the self-test block.
    input wire slt_pkg::slt_fe_t feCtrl,
    // When high, every step reports an angle that is off by a large error.
    input wire logic fault,
    // Measured angle back to the block.
    output logic [11:0] angleIn
);
    // Free-running pattern shown while no test configuration is driven.
    logic [11:0] idleCnt = 12'h000;

    // The pattern moves every cycle so a stale angle is never mistaken for a valid one.
    always_ff @(posedge clk) begin
        idleCnt <= idleCnt + 12'h5a3;
    end

    // Each element step stands for 45 degrees; a fault adds half a step of error.
    always_comb begin
        if (feCtrl.testCfg) begin
            angleIn = {feCtrl.elementSel, 9'h000} + (fault ? 12'h100 : 12'h000);
        end else begin
            angleIn = idleCnt;
        end
    end
endmodule

// file: tb_logic_and_hall_self_test.sv
`timescale 1ns/1ps
`include "slt_regs.svh"

// ****************************************
// Bench for the self-test block.
// ****************************************
module tb_logic_and_hall_self_test;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic fault = 1'b0;
    logic [11:0] angleIn;
    slt_pkg::slt_fe_t feCtrl;
    int fails = 0;
    int total_checks = 0;
    // Last read data and error answer of the bus.
    logic [31:0] rd;
    logic err;
    logic [30:0] sig;

    // Short counts keep the run brief: logic test 64 cycles, transducer 8 x 16.
    slt_self_test #(.LOGIC_TEST_CYC(64), .HALL_STEP_CYC(16)) u_slt_self_test (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .irq(irq), .feCtrl(feCtrl), .angleIn(angleIn));
    slt_fe_model u_slt_fe_model (.clk(clk), .feCtrl(feCtrl), .fault(fault), .angleIn(angleIn));

    // The clock toggles every half period of 2.5 ns.
    always #2.5 clk = ~clk;

    // Prints the counts and the verdict, then stops.
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compares one value and counts it.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; the request holds until pready is sampled high, then one idle edge
    // passes so that a following call never drives the same signal twice in one time step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready wait", 32'h1, n);
        @(posedge clk);
    endtask

    // Reads a register and compares the masked value.
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd & m);
    endtask

    // Reset values, an unmapped access and the power-up launch of both tests.
    task automatic t_reset;
        rdchk("status", `SLT_STATUS_OFS, 32'h5, 32'h5);
        rdchk("cfg", `SLT_CFG_OFS, 32'h7, 32'h3);
        rdchk("imask", `SLT_IMASK_OFS, 32'h7, 32'h0);
        rdchk("expsig", `SLT_EXPSIG_OFS, 32'h7fffffff, 32'h2a5f13c7);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        repeat (140) @(posedge clk);
        rdchk("status done", `SLT_STATUS_OFS, 32'hf, 32'ha);
        $display("test reset done");
    endtask

    // A matching signature passes and a mismatching one raises the sticky fail.
    task automatic t_signature;
        apb(1'b0, `SLT_SIG_OFS, 32'h0);
        sig = rd[30:0];
        apb(1'b1, `SLT_EXPSIG_OFS, {1'b0, sig});
        apb(1'b1, `SLT_ERR_OFS, 32'h1);
        rdchk("err cleared", `SLT_ERR_OFS, 32'h1, 32'h0);
        apb(1'b1, `SLT_CTRL_OFS, 32'h2);
        repeat (80) @(posedge clk);
        rdchk("err match", `SLT_ERR_OFS, 32'h1, 32'h0);
        rdchk("sig repeat", `SLT_SIG_OFS, 32'h7fffffff, {1'b0, sig});
        apb(1'b1, `SLT_EXPSIG_OFS, {1'b0, sig ^ 31'h1});
        apb(1'b1, `SLT_CTRL_OFS, 32'h2);
        repeat (80) @(posedge clk);
        rdchk("err mismatch", `SLT_ERR_OFS, 32'h1, 32'h1);
        rdchk("err sticky", `SLT_ERR_OFS, 32'h1, 32'h1);
        apb(1'b1, `SLT_EXPSIG_OFS, {1'b0, sig});
        apb(1'b1, `SLT_ERR_OFS, 32'h1);
        $display("test signature done");
    endtask

    // Both tests together; the front end steps through all eight positions.
    task automatic t_hall;
        logic [7:0] seen;
        seen = 8'h00;
        apb(1'b1, `SLT_CTRL_OFS, 32'h2);
        apb(1'b1, `SLT_CTRL_OFS, 32'h1);
        rdchk("both run", `SLT_STATUS_OFS, 32'h7, 32'h5);
        repeat (140) begin
            @(posedge clk);
            if (feCtrl.testCfg === 1'b1) begin
                seen[feCtrl.elementSel] = 1'b1;
                chk("dir", {31'h0, feCtrl.elementSel[2]}, {31'h0, feCtrl.currentDir});
            end
        end
        chk("steps", 32'hff, {24'h0, seen});
        chk("test cfg off", 32'h0, {31'h0, feCtrl.testCfg});
        rdchk("hall done", `SLT_STATUS_OFS, 32'hf, 32'ha);
        rdchk("no fail", `SLT_ERR_OFS, 32'h1, 32'h0);
        $display("test hall done");
    endtask

    // The block bit makes the special start command ineffective.
    task automatic t_block;
        apb(1'b1, `SLT_CFG_OFS, 32'h7);
        apb(1'b1, `SLT_CTRL_OFS, 32'h1);
        rdchk("blocked", `SLT_STATUS_OFS, 32'h3, 32'h2);
        apb(1'b1, `SLT_CFG_OFS, 32'h3);
        $display("test block done");
    endtask

    // A wrong angle fails the test; the event interrupts are masked and cleared.
    task automatic t_fault_irq;
        fault <= 1'b1;
        apb(1'b1, `SLT_ISTAT_OFS, 32'h7);
        apb(1'b1, `SLT_CTRL_OFS, 32'h1);
        repeat (140) @(posedge clk);
        rdchk("fail set", `SLT_ERR_OFS, 32'h1, 32'h1);
        rdchk("istat", `SLT_ISTAT_OFS, 32'h7, 32'h5);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, `SLT_IMASK_OFS, 32'h4);
        @(posedge clk);
        chk("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, `SLT_ISTAT_OFS, 32'h4);
        @(posedge clk);
        chk("irq off", 32'h0, {31'h0, irq});
        fault <= 1'b0;
        $display("test fault and irq done");
    endtask

    // Main sequence: reset for 16 cycles, then every scenario in turn.
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_signature();
        t_hall();
        t_block();
        t_fault_irq();
        summarize();
    end

    // Watchdog well beyond the several hundred cycles the scenarios need.
    initial begin
        repeat (6000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule
